// [bench/tbst_host_model.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// Host processor model
// ------------------------------------------------------------
// Every strobe lasts exactly one cycle, so no command is taken twice.
module tbst_host_model (
    input  logic        clk,
    output logic        cmdWrite,
    output logic [7:0]  cmdCode,
    output logic [15:0] paramWordZero,
    output logic        ptpWrite,
    output logic [15:0] ptpData,
    output logic        txCrcDisable,
    output logic        semaphoreClear,
    output logic [7:0]  intClearMask
);
    initial begin
        cmdWrite       = 1'b0;
        cmdCode        = 8'h00;
        paramWordZero  = 16'h0000;
        ptpWrite       = 1'b0;
        ptpData        = 16'h0000;
        txCrcDisable   = 1'b0;
        semaphoreClear = 1'b0;
        intClearMask   = 8'h00;
    end

    task automatic issue(input logic [7:0] code);
        @(negedge clk);
        cmdWrite <= 1'b1;
        cmdCode  <= code;
        @(negedge clk);
        cmdWrite <= 1'b0;
    endtask

    task automatic setPtp(input logic [15:0] val);
        @(negedge clk);
        ptpWrite <= 1'b1;
        ptpData  <= val;
        @(negedge clk);
        ptpWrite <= 1'b0;
    endtask

    // Pattern and CRC mode are set before the test starts and then held.
    task automatic setup(input logic [15:0] pat, input logic crcOff);
        @(negedge clk);
        paramWordZero <= pat;
        txCrcDisable  <= crcOff;
    endtask

    task automatic hostClear(input logic [7:0] mask, input logic sem);
        @(negedge clk);
        intClearMask   <= mask;
        semaphoreClear <= sem;
        @(negedge clk);
        intClearMask   <= 8'h00;
        semaphoreClear <= 1'b0;
    endtask
endmodule // tbst_host_model

// [bench/token_bus_receiver_self_test_tb.sv]
`timescale 1ns/1ps
module token_bus_receiver_self_test_tb;
    import tbst_pkg::*;
    localparam logic [7:0] OFF_CODE = 8'h01;
    localparam logic [7:0] RST_CODE = 8'h02;
    localparam logic [7:0] LFC_CODE = 8'h03;
    localparam logic [7:0] SD_OCTET = 8'hA5;
    // Codes follow the host's order of tests.
    localparam logic [7:0] CODES [5] = '{CMD_HOST_TEST, CMD_LOOP_TEST, CMD_RX_TEST,
                                         CMD_TX_TEST_A, CMD_TX_TEST_B};
    localparam tbst_test_t MODES [5] = '{TBST_TEST_HOST, TBST_TEST_LOOP, TBST_TEST_RX,
                                         TBST_TEST_TX, TBST_TEST_TX};

    logic clk, srst, cmdWrite, ptpWrite, txCrcDisable, semaphoreClear;
    logic rxFrameDone, rxCrcError, rxOverrun, fdPoolEmpty, bdPoolEmpty;
    logic cmdConfirm, fdWrite;
    logic [7:0] cmdCode, intClearMask, cmdResult, semValue, intStatusZero;
    logic [15:0] paramWordZero, ptpData, testFramePreambleParam;
    logic [5:0] rxLength;
    tbst_line_t lineOut;
    tbst_fd_status_t fdStatus;
    tbst_test_t testMode;
    int nFail = 0;
    int checkCount = 0;
    int cycles = 0;

    tbst_self_test #(.CMD_LEAVE_NETWORK_COMMAND(OFF_CODE), .CMD_RESET(RST_CODE), .CMD_LOAD_FC(LFC_CODE),
        .START_DELIMITER(SD_OCTET)) dut (
        .clk(clk), .srst(srst), .cmdWrite(cmdWrite), .cmdCode(cmdCode),
        .paramWordZero(paramWordZero), .ptpWrite(ptpWrite), .ptpData(ptpData),
        .txCrcDisable(txCrcDisable), .semaphoreClear(semaphoreClear),
        .rxFrameDone(rxFrameDone), .rxCrcError(rxCrcError), .rxOverrun(rxOverrun),
        .rxLength(rxLength), .fdPoolEmpty(fdPoolEmpty), .bdPoolEmpty(bdPoolEmpty),
        .intClearMask(intClearMask), .lineOut(lineOut), .cmdConfirm(cmdConfirm),
        .cmdResult(cmdResult), .semValue(semValue), .intStatusZero(intStatusZero),
        .fdWrite(fdWrite), .fdStatus(fdStatus),
        .testFramePreambleParam(testFramePreambleParam), .testMode(testMode));

    tbst_host_model host (.clk(clk), .cmdWrite(cmdWrite), .cmdCode(cmdCode),
        .paramWordZero(paramWordZero), .ptpWrite(ptpWrite), .ptpData(ptpData),
        .txCrcDisable(txCrcDisable), .semaphoreClear(semaphoreClear),
        .intClearMask(intClearMask));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            nFail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic testDone();
        $display("checks %0d mismatches %0d", checkCount, nFail);
        if (nFail == 0 && checkCount > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    function automatic logic [31:0] crcStep(input logic [31:0] c, input logic [7:0] d);
        c = c ^ {24'h00_0000, d};
        for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        return c;
    endfunction

    // Stands in for the receiver and the pool manager: one-cycle event pulse.
    task automatic rxEvent(input logic done, input logic err, input logic ovr,
                           input logic [5:0] len, input logic fdE, input logic bdE);
        @(negedge clk);
        {rxFrameDone, rxCrcError, rxOverrun, rxLength} <= {done, err, ovr, len};
        {fdPoolEmpty, bdPoolEmpty} <= {fdE, bdE};
        @(negedge clk);
        {rxFrameDone, fdPoolEmpty, bdPoolEmpty} <= 3'b000;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic testResetSem();
        chk("mode", testMode, TBST_TEST_NONE);
        chk("line", lineOut, 11'h000);
        chk("ptp reset", testFramePreambleParam, PTP_RESET);
        chk("sem reset", semValue, SEM_RESET);
        host.issue(RST_CODE);
        chk("sem after reset cmd", semValue, SEM_READY);
        host.hostClear(8'h00, 1'b1);
        chk("sem cleared", semValue, SEM_RESET);
        host.issue(LFC_CODE);
        chk("sem after load fc", semValue, SEM_READY);
        host.issue(8'h77);
        chk("unknown confirm", cmdConfirm, 1'b0);
    endtask

    task automatic testCodes();
        for (int i = 0; i < 5; i++) begin
            host.issue(CODES[i]);
            chk("confirm", cmdConfirm, 1'b1);
            chk("test mode", testMode, MODES[i]);
        end
        @(negedge clk);
        chk("confirm pulse", cmdConfirm, 1'b0);
        host.issue(OFF_CODE);
        chk("leave_network_command confirm", cmdConfirm, 1'b1);
        chk("leave_network_command result", cmdResult, RESULT_RESET);
        chk("leave_network_command mode", testMode, TBST_TEST_NONE);
    endtask

    task automatic testFrame(input logic [15:0] test_frame_preamble_param, input logic [15:0] pat, input logic crcOff);
        logic [7:0]  q[$];
        logic [31:0] crc;
        int          m;
        int          b;
        m   = test_frame_preamble_param[15:11];
        b   = test_frame_preamble_param[10:8];
        crc = CRC_INIT;
        host.setPtp(test_frame_preamble_param);
        chk("ptp readback", testFramePreambleParam, test_frame_preamble_param);
        host.setup(pat, crcOff);
        for (int i = 0; i <= b; i++) q.push_back(test_frame_preamble_param[7:0]);
        q.push_back(SD_OCTET);
        for (int i = 0; i <= m; i++) begin
            q.push_back(i[0] ? pat[15:8] : pat[7:0]);
            crc = crcStep(crc, q[$]);
        end
        crc = ~crc;
        if (!crcOff) for (int i = 0; i < 4; i++) q.push_back(crc[8*i +: 8]);
        q.push_back(test_frame_preamble_param[7:0]);
        host.issue(CMD_RX_TEST);
        chk("idle gap", lineOut.valid, 1'b0);
        // The generator spends one more cycle idle before the first preamble octet.
        @(negedge clk);
        chk("idle gap 2", lineOut.valid, 1'b0);
        foreach (q[i]) begin
            @(negedge clk);
            chk("octet", {lineOut.valid, lineOut.octet}, {1'b1, q[i]});
            chk("frame start", lineOut.frameStart, i == b + 1);
            chk("frame end", lineOut.frameEnd, i == q.size() - 2);
        end
        host.issue(OFF_CODE);
        // The octet launched on the leave_network_command edge still stands; valid drops one cycle later.
        @(negedge clk);
        chk("valid drop", lineOut.valid, 1'b0);
    endtask

    task automatic testStatus();
        host.issue(CMD_RX_TEST);
        rxEvent(1'b1, 1'b1, 1'b0, 6'd33, 1'b1, 1'b0);
        chk("fd write", fdWrite, 1'b1);
        chk("fd status", fdStatus, {RX_TEST_CLASS, 1'b1, 1'b0, 6'd33});
        chk("fd pool flag", intStatusZero[INT_FD_POOL_BIT], 1'b1);
        rxEvent(1'b1, 1'b0, 1'b1, 6'd2, 1'b0, 1'b1);
        chk("fd status 2", fdStatus, {RX_TEST_CLASS, 1'b0, 1'b1, 6'd2});
        chk("pool flags", intStatusZero, 8'h06);
        host.hostClear(8'h02, 1'b0);
        chk("pool clear", intStatusZero, 8'h04);
        host.issue(OFF_CODE);
        rxEvent(1'b1, 1'b0, 1'b0, 6'd5, 1'b0, 1'b0);
        chk("fd write idle", fdWrite, 1'b0);
    endtask

    task automatic testTxResult(input logic [7:0] code, input logic err);
        host.issue(code);
        rxEvent(1'b1, err, 1'b0, 6'd9, 1'b0, 1'b0);
        host.issue(OFF_CODE);
        chk("tx confirm", cmdConfirm, 1'b1);
        chk("tx error bit", cmdResult[RES_TXERR_BIT], err);
    endtask

    // A failed test is followed by a full reinitialisation, here cut into a running frame.
    task automatic testReinit();
        host.issue(CMD_RX_TEST);
        rxEvent(1'b1, 1'b1, 1'b1, 6'd7, 1'b1, 1'b1);
        repeat (4) @(negedge clk);
        srst = 1'b1;
        repeat (3) @(negedge clk);
        srst = 1'b0;
        chk("reinit mode", testMode, TBST_TEST_NONE);
        chk("reinit int", intStatusZero, INT_RESET);
        chk("reinit fd", fdStatus, 11'h000);
        @(negedge clk);
        chk("reinit line", lineOut, 11'h000);
        chk("reinit sem", semValue, SEM_RESET);
        host.issue(RST_CODE);
        chk("reinit ready", semValue, SEM_READY);
    endtask

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Long frames take under a hundred cycles, so this leaves ample margin.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            nFail++;
            testDone();
        end
    end

    initial begin
        srst = 1'b1;
        {rxFrameDone, rxCrcError, rxOverrun, rxLength, fdPoolEmpty, bdPoolEmpty} = '0;
        repeat (3) @(negedge clk);
        srst = 1'b0;
        @(negedge clk);
        testResetSem();
        testCodes();
        testFrame(16'hFF55, 16'h3C3C, 1'b0);
        testFrame(16'h10E7, 16'h12AB, 1'b1);
        testStatus();
        testTxResult(CMD_TX_TEST_A, 1'b1);
        testTxResult(CMD_TX_TEST_B, 1'b0);
        testReinit();
        testDone();
    end
endmodule // token_bus_receiver_self_test_tb

// [verilog/tbst_pkg.sv]
package tbst_pkg;

    // ------------------------------------------------------------
    // Command codes and semaphore values
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_RX_TEST     = 8'hB0;
    localparam logic [7:0] CMD_TX_TEST_A   = 8'hB4;
    localparam logic [7:0] CMD_TX_TEST_B   = 8'hB6;
    localparam logic [7:0] CMD_LOOP_TEST   = 8'hB8;
    localparam logic [7:0] CMD_HOST_TEST   = 8'hBC;
    localparam logic [7:0] SEM_READY       = 8'hFF;
    localparam logic [7:0] SEM_RESET       = 8'h00;

    // ------------------------------------------------------------
    // Test frame and preamble parameter layout
    // ------------------------------------------------------------
    localparam int         PTP_LEN_MSB     = 15;
    localparam int         PTP_LEN_LSB     = 11;
    localparam int         PTP_PRE_MSB     = 10;
    localparam int         PTP_PRE_LSB     = 8;
    localparam int         PTP_PAT_MSB     = 7;
    localparam int         PTP_PAT_LSB     = 0;
    localparam logic [15:0] PTP_RESET      = 16'h0000;
    localparam int         LEN_BIAS        = 2;
    localparam int         PRE_BIAS        = 1;
    localparam int         MAX_FRAME_BYTES = 33;

    // ------------------------------------------------------------
    // Status words and descriptors
    // ------------------------------------------------------------
    localparam int         INT_FD_POOL_BIT = 1;
    localparam int         INT_BD_POOL_BIT = 2;
    localparam int         RES_TXERR_BIT   = 1;
    localparam logic [2:0] RX_TEST_CLASS   = 3'h6;
    localparam logic [7:0] RESULT_RESET    = 8'h00;
    localparam logic [7:0] INT_RESET       = 8'h00;

    // ------------------------------------------------------------
    // Frame check sequence
    // ------------------------------------------------------------
    localparam logic [31:0] CRC_INIT       = 32'hFFFF_FFFF;
    localparam logic [31:0] CRC_POLY       = 32'hEDB8_8320;
    localparam logic [1:0]  CRC_LAST_IDX   = 2'h3;

    typedef enum logic [2:0] {
        TBST_TEST_NONE = 3'b000,
        TBST_TEST_HOST = 3'b001,
        TBST_TEST_LOOP = 3'b010,
        TBST_TEST_TX   = 3'b011,
        TBST_TEST_RX   = 3'b100
    } tbst_test_t;

    typedef enum logic [2:0] {
        TBST_GEN_IDLE  = 3'b000,
        TBST_GEN_PRE   = 3'b001,
        TBST_GEN_DELIM = 3'b010,
        TBST_GEN_DATA  = 3'b011,
        TBST_GEN_CRC   = 3'b100
    } tbst_gen_t;

    typedef struct packed {
        logic       valid;
        logic       frameStart;
        logic       frameEnd;
        logic [7:0] octet;
    } tbst_line_t;

    typedef struct packed {
        logic [2:0] accessClass;
        logic       crcError;
        logic       overrun;
        logic [5:0] length;
    } tbst_fd_status_t;

endpackage

// [verilog/tbst_self_test.sv]
`timescale 1ns/1ps
// Summary of operation
// - Receiver test sends a repeating host pattern in frames of at most 33 bytes.
// - Pattern word sits between start delimiter and CRC, low byte first.
// - Device makes the CRC in receiver test; host keeps CRC disable clear. The bench sets it for one receiver test frame, which then has no CRC.
// - Parameter bits 15..11 give frame length, delimiter to CRC, minus two.
// - Parameter bits 10..8 give preamble octets between frames minus one.
// - Parameter bits 7..0 give the preamble octet value.
// - Completing the leave_network_command command sets confirmation and writes return status.
// - Each received test frame gets status in a class 6 frame descriptor.
// - Code B0 starts the receiver test; acceptance is confirmed.
// - Pool exhaustion flags bits 1 and 2 of status word 0; host goes leave_network_command.
// - Reset and table code load set semaphore to FF; host waits.
// - Codes BC, B8, B4 and B6 start the other three tests.
// - Leave_network_command ending transmitter test sets result bit 1 on CRC or overrun.
// - With CRC disable set, no generated CRC is appended.
module tbst_self_test
    import tbst_pkg::*;
#(
    parameter logic [7:0] CMD_LEAVE_NETWORK_COMMAND     = 8'h01,
    parameter logic [7:0] CMD_RESET       = 8'h02,
    parameter logic [7:0] CMD_LOAD_FC     = 8'h03,
    parameter logic [7:0] START_DELIMITER = 8'hA5
) (
    input  wire logic            clk,
    input  wire logic            srst,
    input  wire logic            cmdWrite,
    input  wire logic [7:0]      cmdCode,
    input  wire logic [15:0]     paramWordZero,
    input  wire logic            ptpWrite,
    input  wire logic [15:0]     ptpData,
    input  wire logic            txCrcDisable,
    input  wire logic            semaphoreClear,
    input  wire logic            rxFrameDone,
    input  wire logic            rxCrcError,
    input  wire logic            rxOverrun,
    input  wire logic [5:0]      rxLength,
    input  wire logic            fdPoolEmpty,
    input  wire logic            bdPoolEmpty,
    input  wire logic [7:0]      intClearMask,
    output tbst_line_t           lineOut,
    output logic                 cmdConfirm,
    output logic [7:0]           cmdResult,
    output logic [7:0]           semValue,
    output logic [7:0]           intStatusZero,
    output logic                 fdWrite,
    output tbst_fd_status_t      fdStatus,
    output logic [15:0]          testFramePreambleParam,
    output tbst_test_t           testMode
);

    function automatic logic [31:0] crcByte(input logic [31:0] crc, input logic [7:0] d);
        logic [31:0] c;
        c = crc ^ {24'h00_0000, d};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction

    // ------------------------------------------------------------
    // Parameter register and command decode
    // ------------------------------------------------------------
    logic [15:0] ptp_ff;
    tbst_test_t  mode_ff;
    logic        txErr_ff;
    logic        confirm_ff;
    logic [7:0]  result_ff;
    logic [7:0]  sem_ff;
    logic [4:0]  lenField;
    logic [2:0]  preField;
    logic [7:0]  patField;

    assign lenField = ptp_ff[PTP_LEN_MSB:PTP_LEN_LSB];
    assign preField = ptp_ff[PTP_PRE_MSB:PTP_PRE_LSB];
    assign patField = ptp_ff[PTP_PAT_MSB:PTP_PAT_LSB];

    always_ff @(posedge clk) begin
        if (srst) begin
            ptp_ff <= PTP_RESET;
        end else if (ptpWrite) begin
            ptp_ff <= ptpData;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            mode_ff    <= TBST_TEST_NONE;
            confirm_ff <= 1'b0;
            result_ff  <= RESULT_RESET;
        end else begin
            confirm_ff <= 1'b0;
            if (cmdWrite) begin
                if (cmdCode == CMD_RX_TEST) begin
                    mode_ff    <= TBST_TEST_RX;
                    confirm_ff <= 1'b1;
                end else if (cmdCode == CMD_HOST_TEST) begin
                    mode_ff    <= TBST_TEST_HOST;
                    confirm_ff <= 1'b1;
                end else if (cmdCode == CMD_LOOP_TEST) begin
                    mode_ff    <= TBST_TEST_LOOP;
                    confirm_ff <= 1'b1;
                end else if (cmdCode == CMD_TX_TEST_A || cmdCode == CMD_TX_TEST_B) begin
                    mode_ff    <= TBST_TEST_TX;
                    confirm_ff <= 1'b1;
                end else if (cmdCode == CMD_LEAVE_NETWORK_COMMAND) begin
                    mode_ff    <= TBST_TEST_NONE;
                    confirm_ff <= 1'b1;
                    result_ff  <= RESULT_RESET;
                    result_ff[RES_TXERR_BIT] <= (mode_ff == TBST_TEST_TX) && txErr_ff;
                end
            end
        end
    end

    // Errors seen by the receiver during the transmitter test are kept until the next transmitter test command clears them.
    always_ff @(posedge clk) begin
        if (srst) begin
            txErr_ff <= 1'b0;
        end else if (cmdWrite && (cmdCode == CMD_TX_TEST_A || cmdCode == CMD_TX_TEST_B)) begin
            txErr_ff <= 1'b0;
        end else if (mode_ff == TBST_TEST_TX && rxFrameDone && (rxCrcError || rxOverrun)) begin
            txErr_ff <= 1'b1;
        end
    end

    // The set wins over a host clear in the same cycle so a ready indication is never lost.
    always_ff @(posedge clk) begin
        if (srst) begin
            sem_ff <= SEM_RESET;
        end else if (cmdWrite && (cmdCode == CMD_RESET || cmdCode == CMD_LOAD_FC)) begin
            sem_ff <= SEM_READY;
        end else if (semaphoreClear) begin
            sem_ff <= SEM_RESET;
        end
    end

    // ------------------------------------------------------------
    // Receive status and pool exhaustion
    // ------------------------------------------------------------
    logic [7:0]      int_ff;
    logic [7:0]      intSet;
    logic            fdWrite_ff;
    tbst_fd_status_t fd_ff;

    always_comb begin
        intSet = 8'h00;
        intSet[INT_FD_POOL_BIT] = fdPoolEmpty;
        intSet[INT_BD_POOL_BIT] = bdPoolEmpty;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            int_ff <= INT_RESET;
        end else begin
            int_ff <= (int_ff & ~intClearMask) | intSet;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            fdWrite_ff <= 1'b0;
            fd_ff      <= '0;
        end else begin
            fdWrite_ff <= rxFrameDone && (mode_ff == TBST_TEST_RX);
            if (rxFrameDone) begin
                fd_ff <= '{accessClass: RX_TEST_CLASS, crcError: rxCrcError,
                           overrun: rxOverrun, length: rxLength};
            end
        end
    end

    // ------------------------------------------------------------
    // Test frame generator
    // ------------------------------------------------------------
    tbst_gen_t  gen_ff;
    logic [4:0] idx_ff;
    logic [2:0] pre_ff;
    logic [1:0] crcIdx_ff;
    logic [31:0] crc_ff;
    logic       crcOn_ff;
    tbst_line_t line_ff;
    logic [7:0] dataOctet;
    logic [31:0] crcOut;

    assign dataOctet = idx_ff[0] ? paramWordZero[15:8] : paramWordZero[7:0];
    assign crcOut    = ~crc_ff;

    // The generator only runs while the receiver test is active; leaving it cuts a frame short.
    always_ff @(posedge clk) begin
        if (srst) begin
            gen_ff    <= TBST_GEN_IDLE;
            idx_ff    <= 5'h00;
            pre_ff    <= 3'h0;
            crcIdx_ff <= 2'h0;
            crc_ff    <= CRC_INIT;
            crcOn_ff  <= 1'b0;
            line_ff   <= '0;
        end else if (mode_ff != TBST_TEST_RX) begin
            gen_ff  <= TBST_GEN_IDLE;
            line_ff <= '0;
        end else begin
            line_ff <= '0;
            unique case (gen_ff)
                TBST_GEN_IDLE: begin
                    gen_ff <= TBST_GEN_PRE;
                    pre_ff <= 3'h0;
                end
                TBST_GEN_PRE: begin
                    line_ff.valid <= 1'b1;
                    line_ff.octet <= patField;
                    pre_ff        <= pre_ff + 3'h1;
                    if (pre_ff == preField) begin
                        gen_ff <= TBST_GEN_DELIM;
                    end
                end
                TBST_GEN_DELIM: begin
                    line_ff.valid      <= 1'b1;
                    line_ff.frameStart <= 1'b1;
                    line_ff.octet      <= START_DELIMITER;
                    idx_ff             <= 5'h00;
                    crc_ff             <= CRC_INIT;
                    crcOn_ff           <= !txCrcDisable;
                    gen_ff             <= TBST_GEN_DATA;
                end
                TBST_GEN_DATA: begin
                    line_ff.valid <= 1'b1;
                    line_ff.octet <= dataOctet;
                    crc_ff        <= crcByte(crc_ff, dataOctet);
                    idx_ff        <= idx_ff + 5'h01;
                    // Delimiter plus lenField+1 pattern bytes gives lenField+2 octets.
                    if (idx_ff == lenField) begin
                        crcIdx_ff <= 2'h0;
                        pre_ff    <= 3'h0;
                        if (crcOn_ff) begin
                            gen_ff <= TBST_GEN_CRC;
                        end else begin
                            line_ff.frameEnd <= 1'b1;
                            gen_ff           <= TBST_GEN_PRE;
                        end
                    end
                end
                TBST_GEN_CRC: begin
                    line_ff.valid <= 1'b1;
                    line_ff.octet <= crcOut[8*crcIdx_ff +: 8];
                    crcIdx_ff     <= crcIdx_ff + 2'h1;
                    if (crcIdx_ff == CRC_LAST_IDX) begin
                        line_ff.frameEnd <= 1'b1;
                        gen_ff           <= TBST_GEN_PRE;
                    end
                end
                default: begin
                    gen_ff <= TBST_GEN_IDLE;
                end
            endcase
        end
    end

    assign lineOut                = line_ff;
    assign cmdConfirm             = confirm_ff;
    assign cmdResult              = result_ff;
    assign semValue               = sem_ff;
    assign intStatusZero          = int_ff;
    assign fdWrite                = fdWrite_ff;
    assign fdStatus               = fd_ff;
    assign testFramePreambleParam = ptp_ff;
    assign testMode               = mode_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    logic [5:0] frameBytes_ff;
    logic [3:0] preRun_ff;

    always_ff @(posedge clk) begin
        if (srst || line_ff.frameStart) begin
            frameBytes_ff <= 6'h01;
        end else if (gen_ff == TBST_GEN_DATA && mode_ff == TBST_TEST_RX) begin
            frameBytes_ff <= frameBytes_ff + 6'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (srst || gen_ff != TBST_GEN_PRE) begin
            preRun_ff <= 4'h0;
        end else if (mode_ff == TBST_TEST_RX) begin
            preRun_ff <= preRun_ff + 4'h1;
        end
    end

    frame_len_a: assert property (frameBytes_ff <= MAX_FRAME_BYTES)
        else $error("Test frame longer than the limit.");
    data_order_a: assert property (gen_ff == TBST_GEN_DATA && mode_ff == TBST_TEST_RX
        |=> lineOut.octet == ($past(idx_ff[0]) ? paramWordZero[15:8] : paramWordZero[7:0]))
        else $error("Pattern byte out of order.");
    crc_gate_a: assert property (gen_ff == TBST_GEN_CRC |-> crcOn_ff)
        else $error("CRC sent while disabled.");
    pre_count_a: assert property (gen_ff == TBST_GEN_DELIM && mode_ff == TBST_TEST_RX
        |-> preRun_ff == {1'b0, preField} + 4'h1)
        else $error("Wrong preamble count.");
    pre_value_a: assert property (gen_ff == TBST_GEN_PRE && mode_ff == TBST_TEST_RX
        |=> lineOut.valid && lineOut.octet == $past(patField))
        else $error("Wrong preamble octet.");
    rx_accept_a: assert property (cmdWrite && cmdCode == CMD_RX_TEST
        |=> cmdConfirm && testMode == TBST_TEST_RX)
        else $error("Receiver test not confirmed.");
    tx_result_a: assert property (cmdWrite && cmdCode == CMD_LEAVE_NETWORK_COMMAND
        && mode_ff == TBST_TEST_TX && txErr_ff |=> cmdConfirm && cmdResult[RES_TXERR_BIT])
        else $error("Transmitter error not reported.");
    sem_ready_a: assert property (cmdWrite && cmdCode == CMD_RESET
        |=> semValue == SEM_READY)
        else $error("Semaphore not set.");
    pool_flag_a: assert property (fdPoolEmpty |=> intStatusZero[INT_FD_POOL_BIT])
        else $error("Pool empty flag lost.");
    fd_class_a: assert property (rxFrameDone && mode_ff == TBST_TEST_RX
        |=> fdWrite && fdStatus.accessClass == RX_TEST_CLASS)
        else $error("Frame status not written to class 6.");

endmodule // tbst_self_test
